// *** verilog/pmc_power_ctrl.sv ***
// Power mode control: rail sequencing, low-power and wait modes, debounced pins, resets
module pmc_power_ctrl
  import pmc_pkg::*;
#(
  parameter int unsigned ADDR_W = 8,
  parameter int unsigned POR_SHORT_CYC = PMC_POR_SHORT_CYC,
  parameter int unsigned POR_LONG_CYC = PMC_POR_LONG_CYC,
  parameter int unsigned DEBOUNCE_CYC = PMC_DEBOUNCE_CYC,
  parameter int unsigned CPU_RST_CYC = PMC_CPU_RST_CYC
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic awvalid,
  output logic awready,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [ADDR_W-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic deep_sleep_req,
  input wire logic push_button_in,
  input wire logic warm_reset_in_n,
  input wire logic batt_cover_in,
  input wire logic reset_delay_sel,
  input wire logic rail_order_sel,
  input wire logic supply_present,
  input wire logic uvlo_in,
  input wire logic overtemp_in,
  input wire logic main_pgood,
  input wire logic core_pgood,
  output logic main_rail_en,
  output logic core_rail_en,
  output logic [2:0] core_rail_vsel,
  output logic ldo_low_power,
  output logic power_on_reset_out_n,
  output logic cpu_reset_out_n,
  output logic power_fail_out_n,
  output logic int_out_n
);

  localparam int unsigned DB_W = $clog2(DEBOUNCE_CYC + 1);
  localparam int unsigned CR_W = $clog2(CPU_RST_CYC + 1);
  localparam logic [DB_W-1:0] DB_LAST = DB_W'(DEBOUNCE_CYC - 1);
  localparam logic [PMC_POR_CNT_W-1:0] POR_SHORT_LAST = PMC_POR_CNT_W'(POR_SHORT_CYC - 1);
  localparam logic [PMC_POR_CNT_W-1:0] POR_LONG_LAST = PMC_POR_CNT_W'(POR_LONG_CYC - 1);
  localparam logic [CR_W-1:0] CR_LOAD = CR_W'(CPU_RST_CYC);

  // All state of the block
  typedef struct packed {
    logic awready;
    logic wready;
    logic aw_held;
    logic w_held;
    logic [ADDR_W-1:0] aw_addr;
    logic [7:0] w_byte;
    logic w_lane0;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [7:0] main_ctrl;
    logic [7:0] core_ctrl;
    logic [7:0] chg_cfg;
    logic [PMC_INT_W-1:0] int_stat;
    logic [PMC_INT_W-1:0] int_mask;
    logic [2:0][DB_W-1:0] db_cnt;
    logic [2:0] db_val;
    pmc_state_t st;
    logic down_to_wait;
    logic por_long;
    logic [PMC_POR_CNT_W-1:0] por_cnt;
    logic [CR_W-1:0] cr_cnt;
    logic lp_and;
    logic main_en;
    logic core_en;
    logic [2:0] vsel;
    logic ldo_lp;
    logic por_n;
    logic cpu_rst_n;
    logic pfail_n;
    logic int_n;
  } pmc_regs_t;

  pmc_regs_t s_q;
  pmc_regs_t s_d;

  always_comb begin
    logic [2:0] raw;
    logic [2:0] rise;
    logic [2:0] fall;
    logic wr_do;
    logic [PMC_INT_W-1:0] ev;
    logic [PMC_INT_W-1:0] clr;
    logic sleep_en;
    logic supply_en;
    logic lp_and;
    logic lp_edge;
    logic fault;
    logic first_pg;
    logic second_pg;
    logic sleep_exit;
    logic [31:0] rd;
    logic rd_ok;
    raw = '0;
    rise = '0;
    fall = '0;
    wr_do = 1'b0;
    ev = '0;
    clr = '0;
    sleep_en = 1'b0;
    supply_en = 1'b0;
    lp_and = 1'b0;
    lp_edge = 1'b0;
    fault = 1'b0;
    first_pg = 1'b0;
    second_pg = 1'b0;
    sleep_exit = 1'b0;
    rd = '0;
    rd_ok = 1'b0;
    s_d = s_q;

    // Debounce: a new level is taken only after it has stood for the whole count
    raw = {batt_cover_in, ~warm_reset_in_n, push_button_in};
    for (int i = 0; i < 3; i++) begin
      if (raw[i] != s_q.db_val[i]) begin
        if (s_q.db_cnt[i] == DB_LAST) begin
          s_d.db_val[i] = raw[i];
          s_d.db_cnt[i] = '0;
        end else begin
          s_d.db_cnt[i] = s_q.db_cnt[i] + DB_W'(1);
        end
      end else begin
        s_d.db_cnt[i] = '0;
      end
    end
    rise = s_d.db_val & ~s_q.db_val;
    fall = s_q.db_val & ~s_d.db_val;

    // AXI write channel: address and data taken in either order
    if (awvalid && s_q.awready) begin
      s_d.aw_held = 1'b1;
      s_d.awready = 1'b0;
      s_d.aw_addr = awaddr;
    end
    if (wvalid && s_q.wready) begin
      s_d.w_held = 1'b1;
      s_d.wready = 1'b0;
      s_d.w_byte = wdata[7:0];
      s_d.w_lane0 = wstrb[0];
    end
    wr_do = s_q.aw_held && s_q.w_held && !s_q.bvalid;
    if (wr_do) begin
      s_d.aw_held = 1'b0;
      s_d.w_held = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = PMC_RESP_OKAY;
      if (s_q.aw_addr == ADDR_W'(PMC_OFS_MAIN_CTRL)) begin
        if (s_q.w_lane0) s_d.main_ctrl = s_q.w_byte;
      end else if (s_q.aw_addr == ADDR_W'(PMC_OFS_CORE_CTRL)) begin
        if (s_q.w_lane0) s_d.core_ctrl = s_q.w_byte;
      end else if (s_q.aw_addr == ADDR_W'(PMC_OFS_CHG_CFG)) begin
        if (s_q.w_lane0) s_d.chg_cfg = s_q.w_byte;
      end else if (s_q.aw_addr == ADDR_W'(PMC_OFS_INT_STAT)) begin
        if (s_q.w_lane0) clr = s_q.w_byte[PMC_INT_W-1:0];
      end else if (s_q.aw_addr == ADDR_W'(PMC_OFS_INT_MASK)) begin
        if (s_q.w_lane0) s_d.int_mask = s_q.w_byte[PMC_INT_W-1:0];
      end else if (s_q.aw_addr == ADDR_W'(PMC_OFS_STATUS)) begin
        s_d.bresp = PMC_RESP_OKAY; // Read-only, write ignored
      end else begin
        s_d.bresp = PMC_RESP_SLVERR;
      end
    end
    // Ready again only once the response has gone, so one write is in flight
    if (s_q.bvalid && bready) begin
      s_d.bvalid = 1'b0;
      s_d.awready = 1'b1;
      s_d.wready = 1'b1;
    end

    // AXI read channel
    if (s_q.arready && arvalid) begin
      rd_ok = 1'b1;
      if (araddr == ADDR_W'(PMC_OFS_MAIN_CTRL)) begin
        rd = {24'h000000, s_q.main_ctrl};
      end else if (araddr == ADDR_W'(PMC_OFS_CORE_CTRL)) begin
        rd = {24'h000000, s_q.core_ctrl};
      end else if (araddr == ADDR_W'(PMC_OFS_CHG_CFG)) begin
        rd = {24'h000000, s_q.chg_cfg};
      end else if (araddr == ADDR_W'(PMC_OFS_INT_STAT)) begin
        rd = {29'h00000000, s_q.int_stat};
      end else if (araddr == ADDR_W'(PMC_OFS_INT_MASK)) begin
        rd = {29'h00000000, s_q.int_mask};
      end else if (araddr == ADDR_W'(PMC_OFS_STATUS)) begin
        rd = {19'h00000, 4'(s_q.st), s_q.db_val, s_q.ldo_lp, s_q.por_n, s_q.cpu_rst_n,
              s_q.pfail_n, s_q.core_en, s_q.main_en};
      end else begin
        rd_ok = 1'b0;
      end
      s_d.rvalid = 1'b1;
      s_d.arready = 1'b0;
      s_d.rdata = rd;
      s_d.rresp = rd_ok ? PMC_RESP_OKAY : PMC_RESP_SLVERR;
    end
    if (s_q.rvalid && rready) begin
      s_d.rvalid = 1'b0;
      s_d.arready = 1'b1;
    end

    // Control bits seen by the sequencer
    sleep_en = s_q.main_ctrl[PMC_MAIN_SLEEP_EN_BIT];
    supply_en = s_q.main_ctrl[PMC_MAIN_SUPPLY_EN_BIT];
    lp_and = deep_sleep_req & sleep_en;
    s_d.lp_and = lp_and;
    lp_edge = lp_and & ~s_q.lp_and;
    fault = uvlo_in | overtemp_in | ~s_q.db_val[2];
    first_pg = rail_order_sel ? main_pgood : core_pgood;
    second_pg = rail_order_sel ? core_pgood : main_pgood;

    // Cpu reset pulse counts down; warm reset loads it only with core in regulation
    if (s_q.cr_cnt != '0) s_d.cr_cnt = s_q.cr_cnt - CR_W'(1);
    if (rise[1] && core_pgood && (s_q.st == PMC_ST_ON || s_q.st == PMC_ST_SLEEP)) begin
      s_d.cr_cnt = CR_LOAD;
    end

    // Power sequencer
    case (s_q.st)
      PMC_ST_OFF: begin
        if (!fault) begin
          s_d.st = PMC_ST_RAMP1;
          s_d.ldo_lp = 1'b0;
        end
      end
      PMC_ST_RAMP1: begin
        if (rail_order_sel) s_d.main_en = 1'b1;
        else s_d.core_en = 1'b1;
        if (fault) begin
          s_d.st = PMC_ST_DOWN1;
          s_d.down_to_wait = 1'b0;
        end else if (first_pg) begin
          s_d.st = PMC_ST_RAMP2;
        end
      end
      PMC_ST_RAMP2: begin
        s_d.main_en = 1'b1;
        s_d.core_en = 1'b1;
        if (fault) begin
          s_d.st = PMC_ST_DOWN1;
          s_d.down_to_wait = 1'b0;
        end else if (second_pg) begin
          s_d.st = PMC_ST_POR;
          s_d.por_cnt = '0;
          s_d.por_long = reset_delay_sel;
        end
      end
      PMC_ST_POR: begin
        // Count restarts whenever the main rail drops out of regulation
        if (fault) begin
          s_d.st = PMC_ST_DOWN1;
          s_d.down_to_wait = 1'b0;
        end else if (!main_pgood) begin
          s_d.por_cnt = '0;
        end else if (s_q.por_cnt == (s_q.por_long ? POR_LONG_LAST : POR_SHORT_LAST)) begin
          s_d.st = PMC_ST_ON;
        end else begin
          s_d.por_cnt = s_q.por_cnt + PMC_POR_CNT_W'(1);
        end
      end
      PMC_ST_ON: begin
        s_d.core_en = 1'b1;
        s_d.vsel = s_q.core_ctrl[PMC_CORE_VSEL_LSB +: PMC_VSEL_W];
        if (fault) begin
          s_d.st = PMC_ST_DOWN1;
          s_d.down_to_wait = 1'b0;
        end else if (lp_edge && s_q.cr_cnt == '0) begin
          if (!supply_en) begin
            // Wait mode with a charging supply needs the auto-wait bit
            if (!supply_present || s_q.chg_cfg[PMC_CHG_AUTO_WAIT_BIT]) begin
              s_d.st = PMC_ST_DOWN1;
              s_d.down_to_wait = 1'b1;
            end
          end else begin
            s_d.st = PMC_ST_SLEEP;
          end
        end
      end
      PMC_ST_SLEEP: begin
        s_d.vsel = s_q.core_ctrl[PMC_CORE_LPSEL_LSB +: PMC_VSEL_W];
        s_d.core_en = ~s_q.core_ctrl[PMC_CORE_OFF_BIT];
        sleep_exit = !deep_sleep_req || !sleep_en || rise[0] || rise[1];
        if (s_q.cr_cnt != '0) sleep_exit = 1'b1;
        if (fault) begin
          s_d.st = PMC_ST_DOWN1;
          s_d.down_to_wait = 1'b0;
        end else if (sleep_exit) begin
          s_d.st = PMC_ST_ON;
          s_d.core_en = 1'b1;
          s_d.vsel = s_q.core_ctrl[PMC_CORE_VSEL_LSB +: PMC_VSEL_W];
        end
      end
      PMC_ST_DOWN1: begin
        // Second rail up goes down first
        if (rail_order_sel) s_d.core_en = 1'b0;
        else s_d.main_en = 1'b0;
        if (!s_q.db_val[2]) s_d.ldo_lp = 1'b1;
        if (!second_pg) s_d.st = PMC_ST_DOWN2;
      end
      PMC_ST_DOWN2: begin
        s_d.core_en = 1'b0;
        s_d.main_en = 1'b0;
        if (!first_pg) s_d.st = s_q.down_to_wait ? PMC_ST_WAIT : PMC_ST_OFF;
      end
      PMC_ST_WAIT: begin
        // Rails stay off until a button, warm reset or, with auto-wait clear, a charging supply wakes us; a fault sends us to off
        if (fault) begin
          s_d.st = PMC_ST_OFF;
        end else if (rise[0] || rise[1]) begin
          s_d.st = PMC_ST_RAMP1;
        end else if (supply_present && !s_q.chg_cfg[PMC_CHG_AUTO_WAIT_BIT]) begin
          s_d.st = PMC_ST_RAMP1;
        end
      end
      default: s_d.st = PMC_ST_OFF;
    endcase

    // Pin outputs: released reset only in the on and sleep states, entered once the rails are up past the delay
    s_d.por_n = (s_d.st == PMC_ST_ON) || (s_d.st == PMC_ST_SLEEP);
    s_d.cpu_rst_n = s_d.por_n && (s_d.cr_cnt == '0);
    s_d.pfail_n = s_d.por_n && !uvlo_in && !overtemp_in && s_d.db_val[2];

    // Sticky events; a set in the same cycle as its clear wins
    ev[PMC_INT_PB_BIT] = rise[0];
    ev[PMC_INT_WARM_BIT] = rise[1];
    ev[PMC_INT_COVER_BIT] = fall[2];
    s_d.int_stat = (s_q.int_stat & ~clr) | ev;
    s_d.int_n = s_d.por_n && ((s_d.int_stat & ~s_d.int_mask) == '0);

    // Synchronous reset: registers and pins to their quiet values
    if (!aresetn) begin
      s_d = '0;
      s_d.awready = 1'b1;
      s_d.wready = 1'b1;
      s_d.arready = 1'b1;
      s_d.main_ctrl = PMC_MAIN_CTRL_RST;
      s_d.core_ctrl = PMC_CORE_CTRL_RST;
      s_d.chg_cfg = PMC_CHG_CFG_RST;
      s_d.int_mask = PMC_INT_MASK_RST;
      s_d.st = PMC_ST_OFF;
    end
  end

  // State register
  always_ff @(posedge aclk) begin
    s_q <= s_d;
  end

  // Every output is a flip-flop of the state
  assign awready = s_q.awready;
  assign wready = s_q.wready;
  assign bvalid = s_q.bvalid;
  assign bresp = s_q.bresp;
  assign arready = s_q.arready;
  assign rvalid = s_q.rvalid;
  assign rdata = s_q.rdata;
  assign rresp = s_q.rresp;
  assign main_rail_en = s_q.main_en;
  assign core_rail_en = s_q.core_en;
  assign core_rail_vsel = s_q.vsel;
  assign ldo_low_power = s_q.ldo_lp;
  assign power_on_reset_out_n = s_q.por_n;
  assign cpu_reset_out_n = s_q.cpu_rst_n;
  assign power_fail_out_n = s_q.pfail_n;
  assign int_out_n = s_q.int_n;

endmodule

// *** verilog/pmc_pkg.sv ***
// Package with register map, field positions, reset values and timing for the power mode control
package pmc_pkg;

  // Register byte offsets
  localparam logic [7:0] PMC_OFS_MAIN_CTRL = 8'h00;
  localparam logic [7:0] PMC_OFS_CORE_CTRL = 8'h04;
  localparam logic [7:0] PMC_OFS_CHG_CFG = 8'h08;
  localparam logic [7:0] PMC_OFS_INT_STAT = 8'h0C;
  localparam logic [7:0] PMC_OFS_INT_MASK = 8'h10;
  localparam logic [7:0] PMC_OFS_STATUS = 8'h14;

  // Field positions in conv_ctrl_main
  localparam int PMC_MAIN_SLEEP_EN_BIT = 0;
  localparam int PMC_MAIN_SUPPLY_EN_BIT = 1;
  // Field positions in core_conv_ctrl
  localparam int PMC_CORE_VSEL_LSB = 0;
  localparam int PMC_CORE_LPSEL_LSB = 4;
  localparam int PMC_CORE_OFF_BIT = 7;
  localparam int PMC_VSEL_W = 3;
  // Field position in charger_config
  localparam int PMC_CHG_AUTO_WAIT_BIT = 7;
  // Event bits in the interrupt status and mask registers
  localparam int PMC_INT_PB_BIT = 0;
  localparam int PMC_INT_COVER_BIT = 1;
  localparam int PMC_INT_WARM_BIT = 2;
  localparam int PMC_INT_W = 3;

  // Reset values
  localparam logic [7:0] PMC_MAIN_CTRL_RST = 8'h02;
  localparam logic [7:0] PMC_CORE_CTRL_RST = 8'h13;
  localparam logic [7:0] PMC_CHG_CFG_RST = 8'h00;
  localparam logic [2:0] PMC_INT_MASK_RST = 3'h0;

  // AXI responses
  localparam logic [1:0] PMC_RESP_OKAY = 2'h0;
  localparam logic [1:0] PMC_RESP_SLVERR = 2'h2;

  // Timing
  localparam int unsigned PMC_CLK_KHZ = 200000;
  localparam int unsigned PMC_POR_SHORT_MS = 100;
  localparam int unsigned PMC_POR_LONG_MS = 1000;
  localparam int unsigned PMC_POR_SHORT_CYC = PMC_POR_SHORT_MS * PMC_CLK_KHZ;
  localparam int unsigned PMC_POR_LONG_CYC = PMC_POR_LONG_MS * PMC_CLK_KHZ;
  localparam int unsigned PMC_POR_CNT_W = 28;
  localparam int unsigned PMC_DEBOUNCE_CYC = 1024;
  localparam int unsigned PMC_CPU_RST_CYC = 2048;

  // Power states
  typedef enum logic [3:0] {
    PMC_ST_OFF, PMC_ST_RAMP1, PMC_ST_RAMP2, PMC_ST_POR, PMC_ST_ON,
    PMC_ST_SLEEP, PMC_ST_DOWN1, PMC_ST_DOWN2, PMC_ST_WAIT
  } pmc_state_t;

endpackage

// *** verification/pmc_power_ctrl_monitor.sv ***
// Checker for the pin side of the power mode control block
module pmc_power_ctrl_monitor #(
  parameter int unsigned POR_SHORT_CYC = 50,
  parameter int unsigned DEBOUNCE_CYC = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic warm_reset_in_n,
  input wire logic batt_cover_in,
  input wire logic rail_order_sel,
  input wire logic uvlo_in,
  input wire logic overtemp_in,
  input wire logic main_pgood,
  input wire logic core_pgood,
  input wire logic main_rail_en,
  input wire logic core_rail_en,
  input wire logic ldo_low_power,
  input wire logic power_on_reset_out_n,
  input wire logic cpu_reset_out_n,
  input wire logic power_fail_out_n
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] pg_cnt_q;
  logic [7:0] off_cnt_q;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // Saturating runs of main good and of cover removed, so long waits cannot wrap
  always_ff @(posedge aclk) begin
    if (!aresetn || !main_pgood) pg_cnt_q <= 8'h00;
    else if (pg_cnt_q != 8'hFF) pg_cnt_q <= pg_cnt_q + 8'h01;
    if (!aresetn || batt_cover_in) off_cnt_q <= 8'h00;
    else if (off_cnt_q != 8'hFF) off_cnt_q <= off_cnt_q + 8'h01;
  end
  AST_CPU_WITH_POR: assert property (!power_on_reset_out_n |-> !cpu_reset_out_n)
    else $error("cpu reset released while power-on reset low");
  AST_PFAIL_WITH_POR: assert property (!power_on_reset_out_n |-> !power_fail_out_n)
    else $error("power fail released while power-on reset low");
  AST_PFAIL_FAULT: assert property (uvlo_in || overtemp_in |=> !power_fail_out_n)
    else $error("power fail not low on supply or thermal fault");
  AST_PFAIL_COVER: assert property (int'(off_cnt_q) > DEBOUNCE_CYC + 3 |-> !power_fail_out_n)
    else $error("power fail not low after cover removal");
  AST_COVER_SHUTDOWN: assert property (int'(off_cnt_q) == DEBOUNCE_CYC + 3
    |-> ##[1:40] !main_rail_en && !core_rail_en)
    else $error("rails still on after cover removal");
  AST_CPU_PULSE: assert property ($fell(cpu_reset_out_n) && power_on_reset_out_n &&
    power_fail_out_n |-> !cpu_reset_out_n [*7] ##[1:3] cpu_reset_out_n)
    else $error("cpu reset pulse length wrong");
  AST_CPU_CAUSE: assert property ($fell(cpu_reset_out_n) && power_on_reset_out_n &&
    power_fail_out_n |-> !$past(warm_reset_in_n) && $past(core_pgood))
    else $error("cpu reset without warm reset and core good");
  AST_POR_DELAY: assert property ($rose(power_on_reset_out_n)
    |-> int'(pg_cnt_q) >= POR_SHORT_CYC)
    else $error("power-on reset released before delay after main good");
  AST_ORDER_MAIN: assert property ($rose(main_rail_en) && !core_rail_en |-> rail_order_sel)
    else $error("main rail first with core-first order");
  AST_ORDER_CORE: assert property ($rose(core_rail_en) && !main_rail_en |-> !rail_order_sel)
    else $error("core rail first with main-first order");
  COV_POR_UP: cover property ($rose(power_on_reset_out_n));
  COV_CPU_PULSE: cover property ($fell(cpu_reset_out_n) && power_on_reset_out_n);
  COV_LDO_LOW: cover property ($rose(ldo_low_power));
endmodule

bind pmc_power_ctrl pmc_power_ctrl_monitor #(.POR_SHORT_CYC(POR_SHORT_CYC),
  .DEBOUNCE_CYC(DEBOUNCE_CYC)) u_mon (.aclk(aclk), .aresetn(aresetn),
  .warm_reset_in_n(warm_reset_in_n), .batt_cover_in(batt_cover_in),
  .rail_order_sel(rail_order_sel), .uvlo_in(uvlo_in), .overtemp_in(overtemp_in),
  .main_pgood(main_pgood), .core_pgood(core_pgood), .main_rail_en(main_rail_en),
  .core_rail_en(core_rail_en), .ldo_low_power(ldo_low_power),
  .power_on_reset_out_n(power_on_reset_out_n), .cpu_reset_out_n(cpu_reset_out_n),
  .power_fail_out_n(power_fail_out_n));

// *** verification/pmc_far_model.sv ***
// Far-side model: rails with power-good sensing and the processor sleep pin
module pmc_far_model (
  input wire logic aclk,
  input wire logic main_rail_en,
  input wire logic core_rail_en,
  input wire logic sleep_cmd,
  output logic main_pgood,
  output logic core_pgood,
  output logic deep_sleep_req
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [2:0] main_sh_q = 3'h0;
  logic [2:0] core_sh_q = 3'h0;
  logic req_q = 1'b0;
  // Rails take three cycles to settle but collapse at once when disabled
  always @(posedge aclk) begin
    main_sh_q <= {main_sh_q[1:0], main_rail_en};
    core_sh_q <= {core_sh_q[1:0], core_rail_en};
    req_q <= sleep_cmd;
  end
  assign main_pgood = main_sh_q[2] & main_rail_en;
  assign core_pgood = core_sh_q[2] & core_rail_en;
  assign deep_sleep_req = req_q;
endmodule

// *** verification/tb_power_mode_control_pins.sv ***
// Self-checking testbench for the power mode control block
module tb_power_mode_control_pins;
  timeunit 1ns;
  timeprecision 1ps;
  import pmc_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0;
  logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rd_v;
  logic [3:0] wstrb = 4'hF;
  logic sleep_cmd = 1'b0, push_button_in = 1'b0, warm_reset_in_n = 1'b1, batt_cover_in = 1'b1;
  logic reset_delay_sel = 1'b0, rail_order_sel = 1'b0, supply_present = 1'b0;
  logic uvlo_in = 1'b0, overtemp_in = 1'b0;
  logic awready, wready, bvalid, arready, rvalid, main_pgood, core_pgood, deep_sleep_req;
  logic main_rail_en, core_rail_en, ldo_low_power, power_on_reset_out_n, cpu_reset_out_n;
  logic power_fail_out_n, int_out_n;
  logic [1:0] bresp, rresp;
  logic [2:0] core_rail_vsel;
  int miscompares = 0, checks_done = 0;
  // Short counts keep the run brief; expectations below follow these values
  pmc_power_ctrl #(.POR_SHORT_CYC(50), .POR_LONG_CYC(100), .DEBOUNCE_CYC(4),
    .CPU_RST_CYC(8)) u_dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp), .deep_sleep_req(deep_sleep_req), .push_button_in(push_button_in),
    .warm_reset_in_n(warm_reset_in_n), .batt_cover_in(batt_cover_in),
    .reset_delay_sel(reset_delay_sel), .rail_order_sel(rail_order_sel),
    .supply_present(supply_present), .uvlo_in(uvlo_in), .overtemp_in(overtemp_in),
    .main_pgood(main_pgood), .core_pgood(core_pgood), .main_rail_en(main_rail_en),
    .core_rail_en(core_rail_en), .core_rail_vsel(core_rail_vsel),
    .ldo_low_power(ldo_low_power), .power_on_reset_out_n(power_on_reset_out_n),
    .cpu_reset_out_n(cpu_reset_out_n), .power_fail_out_n(power_fail_out_n),
    .int_out_n(int_out_n));
  pmc_far_model u_far (.aclk(aclk), .main_rail_en(main_rail_en), .core_rail_en(core_rail_en),
    .sleep_cmd(sleep_cmd), .main_pgood(main_pgood), .core_pgood(core_pgood),
    .deep_sleep_req(deep_sleep_req));
  initial begin
    forever #2.5 aclk = ~aclk;
  end
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // Address and data offered together, each dropped at its own handshake
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    @(posedge aclk);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    awaddr <= a;
    wdata <= d;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    chk("bresp", {30'h0, er}, {30'h0, bresp});
  endtask
  task automatic rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
    @(posedge aclk);
    arvalid <= 1'b1;
    rready <= 1'b1;
    araddr <= a;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    d = rdata;
    chk("rresp", {30'h0, er}, {30'h0, rresp});
  endtask
  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rd(a, PMC_RESP_OKAY, rd_v);
    chk("rdata", e, rd_v);
  endtask
  task automatic st(input pmc_state_t e);
    rd(PMC_OFS_STATUS, PMC_RESP_OKAY, rd_v);
    chk("state", {28'h0, e}, {28'h0, rd_v[12:9]});
  endtask
  task automatic press(input int n);
    push_button_in <= 1'b1;
    cyc(n);
    push_button_in <= 1'b0;
    cyc(4);
  endtask
  // The watchdog may finish the run while still waiting here
  task automatic up();
    while (power_on_reset_out_n !== 1'b1) @(posedge aclk);
  endtask
  task automatic t_regs();
    rc(PMC_OFS_MAIN_CTRL, {24'h0, PMC_MAIN_CTRL_RST});
    rc(PMC_OFS_CORE_CTRL, {24'h0, PMC_CORE_CTRL_RST});
    rc(PMC_OFS_CHG_CFG, {24'h0, PMC_CHG_CFG_RST});
    rc(PMC_OFS_INT_MASK, {29'h0, PMC_INT_MASK_RST});
    rd(8'h18, PMC_RESP_SLVERR, rd_v);
    chk("unmapped", 32'h0, rd_v);
    wr(8'h18, 32'hFF, PMC_RESP_SLVERR);
    wr(PMC_OFS_STATUS, 32'hFF, PMC_RESP_OKAY);
    up();
    chk("pins", 32'hF, {28'h0, cpu_reset_out_n, power_fail_out_n, int_out_n,
      power_on_reset_out_n});
    $display("test regs done");
  endtask
  task automatic t_sleep();
    sleep_cmd <= 1'b1;
    cyc(6);
    st(PMC_ST_ON);
    wr(PMC_OFS_MAIN_CTRL, 32'h3, PMC_RESP_OKAY);
    cyc(4);
    st(PMC_ST_SLEEP);
    chk("vsel_lp", 32'h1, {29'h0, core_rail_vsel});
    sleep_cmd <= 1'b0;
    cyc(4);
    st(PMC_ST_ON);
    sleep_cmd <= 1'b1;
    cyc(4);
    st(PMC_ST_SLEEP);
    wr(PMC_OFS_MAIN_CTRL, 32'h2, PMC_RESP_OKAY);
    st(PMC_ST_ON);
    wr(PMC_OFS_MAIN_CTRL, 32'h3, PMC_RESP_OKAY);
    cyc(4);
    press(8);
    chk("vsel_back", 32'h3, {29'h0, core_rail_vsel});
    chk("int_pb", 32'h0, {31'h0, int_out_n});
    cyc(20);
    st(PMC_ST_ON);
    wr(PMC_OFS_INT_STAT, 32'h7, PMC_RESP_OKAY);
    wr(PMC_OFS_CORE_CTRL, 32'h93, PMC_RESP_OKAY);
    sleep_cmd <= 1'b0;
    cyc(2);
    sleep_cmd <= 1'b1;
    cyc(4);
    chk("core_off", 32'h0, {31'h0, core_rail_en});
    sleep_cmd <= 1'b0;
    cyc(10);
    chk("core_back", 32'h1, {31'h0, core_rail_en});
    chk("int_clear", 32'h1, {31'h0, int_out_n});
    $display("test sleep done");
  endtask
  task automatic t_button();
    press(2);
    cyc(10);
    chk("glitch", 32'h1, {31'h0, int_out_n});
    wr(PMC_OFS_INT_MASK, 32'h1, PMC_RESP_OKAY);
    press(8);
    chk("int_masked", 32'h1, {31'h0, int_out_n});
    rc(PMC_OFS_INT_STAT, 32'h1);
    wr(PMC_OFS_INT_STAT, 32'h1, PMC_RESP_OKAY);
    wr(PMC_OFS_INT_MASK, 32'h0, PMC_RESP_OKAY);
    $display("test button done");
  endtask
  task automatic t_warm();
    wr(PMC_OFS_CORE_CTRL, 32'h15, PMC_RESP_OKAY);
    sleep_cmd <= 1'b1;
    cyc(4);
    warm_reset_in_n <= 1'b0;
    cyc(8);
    chk("cpu_rst", 32'h0, {31'h0, cpu_reset_out_n});
    st(PMC_ST_ON);
    warm_reset_in_n <= 1'b1;
    rc(PMC_OFS_CORE_CTRL, 32'h15);
    cyc(10);
    chk("cpu_run", 32'h1, {31'h0, cpu_reset_out_n});
    wr(PMC_OFS_INT_STAT, 32'h7, PMC_RESP_OKAY);
    sleep_cmd <= 1'b0;
    $display("test warm done");
  endtask
  task automatic t_por();
    int n;
    n = 0;
    uvlo_in <= 1'b1;
    reset_delay_sel <= 1'b1;
    rail_order_sel <= 1'b1;
    cyc(2);
    chk("pfail_uvlo", 32'h0, {31'h0, power_fail_out_n});
    cyc(20);
    uvlo_in <= 1'b0;
    while (power_on_reset_out_n !== 1'b1) begin
      @(posedge aclk);
      if (main_pgood === 1'b1) n++;
    end
    chk("por_long", 32'h1, {31'h0, n >= 100 && n <= 110});
    $display("test por done");
  endtask
  task automatic t_wait();
    supply_present <= 1'b1;
    wr(PMC_OFS_MAIN_CTRL, 32'h1, PMC_RESP_OKAY);
    sleep_cmd <= 1'b1;
    cyc(60);
    chk("no_wait", 32'h1, {31'h0, main_rail_en});
    up();
    wr(PMC_OFS_CHG_CFG, 32'h80, PMC_RESP_OKAY);
    wr(PMC_OFS_MAIN_CTRL, 32'h1, PMC_RESP_OKAY);
    sleep_cmd <= 1'b0;
    cyc(2);
    sleep_cmd <= 1'b1;
    cyc(40);
    chk("wait_off", 32'h0, {30'h0, main_rail_en, core_rail_en});
    supply_present <= 1'b0;
    sleep_cmd <= 1'b0;
    press(8);
    up();
    wr(PMC_OFS_MAIN_CTRL, 32'h2, PMC_RESP_OKAY);
    $display("test wait done");
  endtask
  task automatic t_cover();
    // Start from a clean status so the cover event alone is seen below
    wr(PMC_OFS_INT_STAT, 32'h7, PMC_RESP_OKAY);
    batt_cover_in <= 1'b0;
    cyc(8);
    chk("pfail_cover", 32'h0, {31'h0, power_fail_out_n});
    chk("int_cover", 32'h0, {31'h0, int_out_n});
    // The pin is held low by power-on reset anyway, so the status bit proves the event
    rc(PMC_OFS_INT_STAT, 32'h2);
    cyc(30);
    chk("shutdown", 32'h1, {29'h0, main_rail_en, core_rail_en, ldo_low_power});
    batt_cover_in <= 1'b1;
    up();
    chk("ldo_back", 32'h0, {31'h0, ldo_low_power});
    $display("test cover done");
  endtask
  initial begin
    cyc(4);
    aresetn <= 1'b1;
    t_regs();
    t_sleep();
    t_button();
    t_warm();
    t_por();
    t_wait();
    t_cover();
    tally_and_finish();
  end
  // Watchdog: the tests need well under a thousand cycles
  initial begin
    cyc(20000);
    miscompares++;
    tally_and_finish();
  end
endmodule
